// >>> bhdp_chk.sv
// assertion checker for the host data port
`timescale 1ns/1ps
`default_nettype none
module bhdp_chk #(parameter CW = 12) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // requests
  input wire logic q_wr,
  input wire logic [3:0] q_be,
  input wire logic [1:0] q_sel,
  input wire logic [31:0] q_wdata,
  input wire logic op_state_wr,
  input wire logic [7:0] op_state_wdata,
  input wire logic [31:0] q_src_addr,
  input wire logic sync_enable,
  input wire logic ap_wr,
  input wire logic [1:0] ap_addr,
  input wire logic [3:0] ap_be,
  input wire logic ap_split,
  // results
  input wire logic mem_we,
  input wire logic host_rvalid,
  input wire logic busy,
  input wire logic write_status,
  input wire logic bus_wait,
  input wire logic write_fault,
  input wire logic [31:0] wk_src_addr,
  input wire logic [31:0] wk_dst_addr,
  input wire logic [CW-1:0] x_pos
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // request shapes
  sequence s_start;
    q_wr && q_sel == 2'h3 && q_be[3] && !busy;
  endsequence
  sequence s_restore;
    op_state_wr && op_state_wdata[0] && !busy;
  endsequence
  sequence s_split;
    ap_wr && !(q_wr && q_sel == 2'h3 && q_be[3]) && ap_split && ap_be == 4'hf && ap_addr != 2'h0;
  endsequence
  start_load_a: assert property (s_start |=> busy && wk_dst_addr == $past(q_wdata)
    && x_pos == {CW{1'b0}}) else $error("start did not load working state");
  restore_copy_a: assert property (s_restore |=> wk_src_addr == $past(q_src_addr))
    else $error("restore did not copy the queue");
  split_fault_a: assert property (s_split |=> write_fault)
    else $error("split write not flagged");
  fault_cause_a: assert property (write_fault |-> $past(ap_wr && ap_split))
    else $error("fault without split write");
  wait_full_a: assert property (ap_wr && !write_status && sync_enable |=> bus_wait)
    else $error("no wait on full queue");
  wait_cause_a: assert property ($rose(bus_wait) |-> $past(sync_enable && !write_status))
    else $error("wait without full queue");
  room_taken_a: assert property (ap_wr && write_status |=> !write_status)
    else $error("accepted write left room shown");
  route_excl_a: assert property (!(mem_we && host_rvalid))
    else $error("result sent both ways");
  out_busy_a: assert property (mem_we || host_rvalid |-> $past(busy))
    else $error("result while idle");
endmodule
bind bhdp_top bhdp_chk #(.CW(CW)) u_chk (.sys_clk, .arst_n, .q_wr, .q_be, .q_sel, .q_wdata,
  .op_state_wr, .op_state_wdata, .q_src_addr, .sync_enable, .ap_wr, .ap_addr, .ap_be, .ap_split,
  .mem_we, .host_rvalid, .busy, .write_status, .bus_wait, .write_fault, .wk_src_addr,
  .wk_dst_addr, .x_pos);
`default_nettype wire

// >>> bhdp_defines.vh
// constants for the blit engine host data port
`ifndef BHDP_DEFINES_VH
`define BHDP_DEFINES_VH
`define BHDP_RESTORE_BIT 0
`define BHDP_RUN_BIT 4
`define BHDP_LANE3 3
`define BHDP_BYTE_LSB 0
`define BHDP_BYTE_MSB 1
`define BHDP_BIT_MSB 4
`define BHDP_ROUTE_MEM 2'h0
`define BHDP_ROUTE_SRC_HOST 2'h1
`define BHDP_ROUTE_MIX_HOST 2'h2
`define BHDP_DIR_INC 1'h0
`define BHDP_ZERO16 16'h0000
`define BHDP_ZERO32 32'h00000000
`define BHDP_ONES32 32'hffffffff
`define BHDP_STEP 32'h00000004
`define BHDP_ROP_NOP 8'haa
`endif

// >>> bhdp_mem_model.sv
// display memory model feeding source, pattern, destination and mix data
`timescale 1ns/1ps
`default_nettype none
module bhdp_mem_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // memory read data
  output logic [7:0] mem_src,
  output logic [7:0] mem_pat,
  output logic [7:0] mem_dst,
  output logic mem_mix
);
  logic [7:0] lfsr_q;
  // data moves every cycle so a stale sample never looks right
  always @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      lfsr_q <= 8'h5a;
    else
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  // pattern always comes from memory
  assign mem_src = lfsr_q;
  assign mem_pat = ~lfsr_q;
  assign mem_dst = lfsr_q ^ 8'h3c;
  assign mem_mix = lfsr_q[2];
endmodule
`default_nettype wire

// >>> bhdp_rop.v
// three-input raster operation selected per pixel by the mix bit
`timescale 1ns/1ps
`default_nettype none
module bhdp_rop
(
  // operands
  input wire [7:0] src,
  input wire [7:0] pat,
  input wire [7:0] dst,
  input wire mix,
  // operation codes
  input wire [7:0] fg_rop,
  input wire [7:0] bg_rop,
  // result
  output reg [7:0] res
);
  integer i;
  reg [7:0] rop;
  // each result bit indexes the rop truth table by pattern, source, destination
  always @*
  begin
    rop = mix ? fg_rop : bg_rop;
    res = 8'h00;
    for (i = 0; i < 8; i = i + 1)
    begin
      res[i] = rop[{pat[i], src[i], dst[i]}];
    end
  end
endmodule
`default_nettype wire

// >>> bhdp_top.v
// host data port of the drawing engine: queue, working state, routing, alignment
// Function
// - queued registers keep their values after transfer into working state.
// - only working state reads back; restore bit 0 copies queue to working state.
// - working map addresses advance; finish pointing at next scan line start.
// - horizontal and vertical positions clear to zero at each start.
// - source and pattern addresses advance only if the rop (or, for source, host source) uses that map; destination always advances.
// - source address low two bits drive the byte rotator for host source.
// - mix address low five bits drive the bit rotator for host mix.
// - destination route select sends result to memory or host.
// - input route select picks mix and source origin; mix fixed one for host source with mix map disabled.
// - pattern from memory; three-input rop chosen per pixel by mix bit.
// - only the two lowest aperture address bits are decoded.
// - rotation derived from source and destination address relation.
// - unaligned out-of-order doubleword write is detected and discarded.
// - host mix lsb first when increasing, msb first when decreasing.
// - write status bit shows room for another data write.
// - with sync enable, wait is held while the data queue is full.
// - a write touching destination address byte lane 3 starts an operation.
// - engine runs only while run enable bit 4 is set.
// - at start queue goes full, copies to working state, then empty.
`timescale 1ns/1ps
`default_nettype none
`include "bhdp_defines.vh"
module bhdp_top
#(
  parameter CW = 12
)
(
  // clock and reset
  input wire sys_clk,
  input wire arst_n,
  // queued register writes from host
  input wire q_wr,
  input wire [3:0] q_be,
  input wire [1:0] q_sel,
  input wire [31:0] q_wdata,
  input wire op_state_wr,
  input wire [7:0] op_state_wdata,
  // queued configuration values
  input wire [31:0] q_mix_addr,
  input wire [31:0] q_pat_addr,
  input wire [31:0] q_src_addr,
  input wire [15:0] q_mix_offset,
  input wire [15:0] q_pat_offset,
  input wire [15:0] q_src_offset,
  input wire [15:0] q_dst_offset,
  input wire [CW-1:0] horizontal_count,
  input wire [CW-1:0] vertical_count,
  input wire [7:0] q_fg_rop,
  input wire [7:0] q_bg_rop,
  input wire destination_route_select,
  input wire [1:0] input_route_select,
  input wire mix_map_enable,
  input wire x_dir,
  input wire sync_enable,
  // host aperture data writes
  input wire ap_wr,
  input wire [1:0] ap_addr,
  input wire [3:0] ap_be,
  input wire [31:0] ap_wdata,
  input wire ap_split,
  // display memory data
  input wire [7:0] mem_src,
  input wire [7:0] mem_pat,
  input wire [7:0] mem_dst,
  input wire mem_mix,
  // results and status
  output reg [7:0] mem_wdata,
  output reg mem_we,
  output reg [7:0] host_rdata,
  output reg host_rvalid,
  output reg busy,
  output reg write_status,
  output reg bus_wait,
  output reg write_fault,
  output reg [31:0] wk_mix_addr,
  output reg [31:0] wk_pat_addr,
  output reg [31:0] wk_src_addr,
  output reg [31:0] wk_dst_addr,
  output reg [CW-1:0] x_pos,
  output reg [CW-1:0] y_pos,
  output reg [1:0] byte_rot,
  output reg [4:0] bit_rot
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam SEL_DST = 2'h3;
  reg [31:0] q_dst_q, data_q, line_mix_q, line_pat_q, line_src_q, line_dst_q;
  reg [1:0] st_q, lane_q, input_route_select_q;
  reg run_en_q, qfull_q, destination_route_select_q, mix_map_enable_q, xdir_q;
  reg [3:0] data_v_q;
  reg [4:0] mix_bit_q;
  reg [7:0] fg_q, bg_q;
  wire [7:0] rop_res;
  // whether a rop code depends on a given operand
  function uses;
    input [7:0] r;
    input [1:0] which;
    begin
      case (which)
        2'h0: uses = (r[7:4] != r[3:0]);
        2'h1: uses = ({r[7:6], r[3:2]} != {r[5:4], r[1:0]});
        default: uses = ({r[6], r[4], r[2], r[0]} != {r[7], r[5], r[3], r[1]});
      endcase
    end
  endfunction

  // stored queue entry (destination address only lives here; others are ports)
  wire start = q_wr && (q_sel == SEL_DST) && q_be[`BHDP_LANE3];
  wire restore = op_state_wr && op_state_wdata[`BHDP_RESTORE_BIT];
  wire host_src = (input_route_select_q == `BHDP_ROUTE_SRC_HOST);
  wire host_mix = (input_route_select_q == `BHDP_ROUTE_MIX_HOST);
  wire host_feed = host_src || host_mix;
  wire cur_byte_v = data_v_q[lane_q];
  wire stall = host_feed && !cur_byte_v;
  wire advance = (st_q == ST_RUN) && run_en_q && !stall;
  wire last_x = (x_pos == horizontal_count);
  wire last_y = (y_pos == vertical_count);
  wire [7:0] src_byte = host_src ? data_q[lane_q*8 +: 8] : mem_src;
  // a start takes its destination from the write itself, not the stale queue entry
  wire [1:0] dst_lo = start ? q_wdata[`BHDP_BYTE_MSB:0] : q_dst_q[`BHDP_BYTE_MSB:0];
  // mix source: host bit, memory, or fixed one
  wire mix_bit = host_mix ? data_q[mix_bit_q] :
    ((host_src && !mix_map_enable_q) ? 1'b1 : mem_mix);
  bhdp_rop u_rop
  (
    .src(src_byte),
    .pat(mem_pat),
    .dst(mem_dst),
    .mix(mix_bit),
    .fg_rop(fg_q),
    .bg_rop(bg_q),
    .res(rop_res)
  );
  // queue holding register; kept after transfer so partial reloads work
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      q_dst_q <= `BHDP_ZERO32;
    else if (q_wr && q_sel == SEL_DST)
      q_dst_q <= q_wdata;
  end
  // run enable, queue flag and engine sequencing
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= ST_IDLE;
      run_en_q <= 1'b0;
      qfull_q <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      if (op_state_wr)
        run_en_q <= op_state_wdata[`BHDP_RUN_BIT];
      // queue full only in the transfer cycle, then empty again
      qfull_q <= start;
      case (st_q)
        ST_IDLE:
          if (start)
          begin
            st_q <= ST_RUN;
            busy <= 1'b1;
          end
        ST_RUN:
          if (advance && last_x && last_y)
          begin
            st_q <= ST_IDLE;
            busy <= 1'b0;
          end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end
  // working state: loaded at start or restore, walked during the operation
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wk_mix_addr <= `BHDP_ZERO32;
      wk_pat_addr <= `BHDP_ZERO32;
      wk_src_addr <= `BHDP_ZERO32;
      wk_dst_addr <= `BHDP_ZERO32;
      line_mix_q <= `BHDP_ZERO32;
      line_pat_q <= `BHDP_ZERO32;
      line_src_q <= `BHDP_ZERO32;
      line_dst_q <= `BHDP_ZERO32;
      x_pos <= {CW{1'b0}};
      y_pos <= {CW{1'b0}};
      fg_q <= `BHDP_ROP_NOP;
      bg_q <= `BHDP_ROP_NOP;
      destination_route_select_q <= 1'b0;
      input_route_select_q <= `BHDP_ROUTE_MEM;
      mix_map_enable_q <= 1'b0;
      xdir_q <= `BHDP_DIR_INC;
      byte_rot <= 2'h0;
      bit_rot <= 5'h00;
    end
    else if ((start && st_q == ST_IDLE) || restore)
    begin
      wk_mix_addr <= q_mix_addr;
      wk_pat_addr <= q_pat_addr;
      wk_src_addr <= q_src_addr;
      wk_dst_addr <= start ? q_wdata : q_dst_q;
      line_mix_q <= q_mix_addr;
      line_pat_q <= q_pat_addr;
      line_src_q <= q_src_addr;
      line_dst_q <= start ? q_wdata : q_dst_q;
      x_pos <= {CW{1'b0}};
      y_pos <= {CW{1'b0}};
      fg_q <= q_fg_rop;
      bg_q <= q_bg_rop;
      destination_route_select_q <= destination_route_select;
      input_route_select_q <= input_route_select;
      mix_map_enable_q <= mix_map_enable;
      xdir_q <= x_dir;
      // byte rotation from source/destination alignment, bit rotation from the mix address
      byte_rot <= q_src_addr[`BHDP_BYTE_MSB:0] - dst_lo;
      bit_rot <= q_mix_addr[`BHDP_BIT_MSB:0];
    end
    else if (advance)
    begin
      if (last_x)
      begin
        // next scan line start; after the last line this is the final pointer
        x_pos <= {CW{1'b0}};
        y_pos <= y_pos + 1'b1;
        if (uses(fg_q, 2'h1) || uses(bg_q, 2'h1) || host_src)
        begin
          line_src_q <= line_src_q + {`BHDP_ZERO16, q_src_offset};
          wk_src_addr <= line_src_q + {`BHDP_ZERO16, q_src_offset};
        end
        if (uses(fg_q, 2'h0) || uses(bg_q, 2'h0))
        begin
          line_pat_q <= line_pat_q + {`BHDP_ZERO16, q_pat_offset};
          wk_pat_addr <= line_pat_q + {`BHDP_ZERO16, q_pat_offset};
        end
        if (host_mix || (mix_map_enable_q && !host_src) || input_route_select_q == `BHDP_ROUTE_MEM)
        begin
          line_mix_q <= line_mix_q + {`BHDP_ZERO16, q_mix_offset};
          wk_mix_addr <= line_mix_q + {`BHDP_ZERO16, q_mix_offset};
        end
        line_dst_q <= line_dst_q + {`BHDP_ZERO16, q_dst_offset};
        wk_dst_addr <= line_dst_q + {`BHDP_ZERO16, q_dst_offset};
      end
      else
      begin
        x_pos <= x_pos + 1'b1;
        if (uses(fg_q, 2'h1) || uses(bg_q, 2'h1) || host_src)
          wk_src_addr <= xdir_q ? wk_src_addr - 1'b1 : wk_src_addr + 1'b1;
        if (uses(fg_q, 2'h0) || uses(bg_q, 2'h0))
          wk_pat_addr <= xdir_q ? wk_pat_addr - 1'b1 : wk_pat_addr + 1'b1;
        wk_dst_addr <= xdir_q ? wk_dst_addr - 1'b1 : wk_dst_addr + 1'b1;
      end
    end
  end
  // host data holding word: bytes land by byte enables ap_be only
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      data_q <= `BHDP_ZERO32;
      data_v_q <= 4'h0;
      lane_q <= 2'h0;
      mix_bit_q <= 5'h00;
      write_fault <= 1'b0;
    end
    else
    begin
      write_fault <= 1'b0;
      if (start)
      begin
        lane_q <= q_src_addr[`BHDP_BYTE_MSB:0];
        mix_bit_q <= input_route_select == `BHDP_ROUTE_MIX_HOST && x_dir ?
          5'h1f - q_mix_addr[`BHDP_BIT_MSB:0] : q_mix_addr[`BHDP_BIT_MSB:0];
        data_v_q <= 4'h0;
      end
      else if (ap_wr && ap_split && (&ap_be) && ap_addr != 2'h0)
        write_fault <= 1'b1; // discard deadlocking cycle
      else if (ap_wr && write_status)
      begin
        // byte lanes follow ap_be; ap_addr above two bits never reaches here
        data_q <= (data_q & ~{{8{ap_be[3]}}, {8{ap_be[2]}}, {8{ap_be[1]}}, {8{ap_be[0]}}}) |
          (ap_wdata & {{8{ap_be[3]}}, {8{ap_be[2]}}, {8{ap_be[1]}}, {8{ap_be[0]}}});
        data_v_q <= data_v_q | ap_be;
      end
      else if (advance && host_src)
      begin
        data_v_q[lane_q] <= 1'b0;
        lane_q <= lane_q + 1'b1;
      end
      else if (advance && host_mix)
      begin
        // lsb first when increasing, msb first when decreasing
        mix_bit_q <= xdir_q ? mix_bit_q - 1'b1 : mix_bit_q + 1'b1;
        if ((!xdir_q && mix_bit_q[2:0] == 3'h7) || (xdir_q && mix_bit_q[2:0] == 3'h0))
          data_v_q[mix_bit_q[4:3]] <= 1'b0;
      end
    end
  end
  // result routing, flow status and wait generation
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
      write_status <= 1'b1;
      bus_wait <= 1'b0;
    end
    else
    begin
      mem_we <= advance && !destination_route_select_q;
      host_rvalid <= advance && destination_route_select_q;
      if (advance && !destination_route_select_q)
        mem_wdata <= rop_res;
      if (advance && destination_route_select_q)
        host_rdata <= rop_res;
      // room only while nothing pends; a write or start in flight clears it early
      write_status <= (data_v_q == 4'h0) && !qfull_q && !ap_wr && !start;
      bus_wait <= sync_enable && ap_wr && !write_status;
    end
  end
endmodule
`default_nettype wire

// >>> tb_blit_engine_host_data_port.sv
// self-checking testbench for the host data port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_blit_engine_host_data_port;
  logic sys_clk = 1'h0, arst_n = 1'h0, q_wr = 1'h0, op_state_wr = 1'h0, ap_wr = 1'h0;
  logic ap_split = 1'h0, destination_route_select = 1'h0, mix_map_enable = 1'h0;
  logic x_dir = 1'h0, sync_enable = 1'h1;
  logic [1:0] q_sel = 2'h0, input_route_select = 2'h0, ap_addr = 2'h0;
  logic [3:0] q_be = 4'h0, ap_be = 4'h0;
  logic [7:0] op_state_wdata = 8'h0, q_fg_rop = 8'hcc, q_bg_rop = 8'hcc;
  logic [11:0] horizontal_count = 12'h3, vertical_count = 12'h1;
  logic [15:0] q_mix_offset = 16'h40, q_pat_offset = 16'h40, q_src_offset = 16'h120;
  logic [15:0] q_dst_offset = 16'h80;
  logic [31:0] q_wdata = 32'h0, q_mix_addr = 32'h0, q_pat_addr = 32'h2000;
  logic [31:0] q_src_addr = 32'h1000, ap_wdata = 32'h0, d;
  logic [7:0] mem_src, mem_pat, mem_dst, mem_wdata, host_rdata;
  logic mem_mix, mem_we, host_rvalid, busy, write_status, bus_wait, write_fault;
  logic [31:0] wk_mix_addr, wk_pat_addr, wk_src_addr, wk_dst_addr;
  logic [11:0] x_pos, y_pos;
  logic [1:0] byte_rot;
  logic [4:0] bit_rot;
  int checks = 0, fail_count = 0, n_mem = 0, n_host = 0, n_flt = 0, seed = 32'hc8ee;
  logic [31:0] exp_q[$];
  logic [7:0] dq[$];
  logic [7:0] src_q = 8'h00;
  logic mix_q = 1'h0;
  bhdp_top #(.CW(12)) dut (.sys_clk, .arst_n, .q_wr, .q_be, .q_sel, .q_wdata, .op_state_wr,
    .op_state_wdata, .q_mix_addr, .q_pat_addr, .q_src_addr, .q_mix_offset, .q_pat_offset,
    .q_src_offset, .q_dst_offset, .horizontal_count, .vertical_count, .q_fg_rop, .q_bg_rop,
    .destination_route_select, .input_route_select, .mix_map_enable, .x_dir, .sync_enable,
    .ap_wr, .ap_addr, .ap_be, .ap_wdata, .ap_split, .mem_src, .mem_pat, .mem_dst, .mem_mix,
    .mem_wdata, .mem_we, .host_rdata, .host_rvalid, .busy, .write_status, .bus_wait,
    .write_fault, .wk_mix_addr, .wk_pat_addr, .wk_src_addr, .wk_dst_addr, .x_pos, .y_pos,
    .byte_rot, .bit_rot);
  bhdp_mem_model u_mem (.sys_clk, .arst_n, .mem_src, .mem_pat, .mem_dst, .mem_mix);
  // clock
  always #2 sys_clk = ~sys_clk;
  task test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task op_state(input logic [7:0] v);
    @(posedge sys_clk);
    op_state_wr <= 1'h1;
    op_state_wdata <= v;
    @(posedge sys_clk);
    op_state_wr <= 1'h0;
  endtask
  // the note goes in before the request so the watcher never sees an empty queue
  task start_op(input logic [31:0] v);
    @(posedge sys_clk);
    exp_q.push_back(v);
    q_wr <= 1'h1;
    q_sel <= 2'h3;
    q_be <= 4'hf;
    q_wdata <= v;
    @(posedge sys_clk);
    q_wr <= 1'h0;
  endtask
  task ap_put(input logic [1:0] a, input logic sp, input logic [31:0] v, input int n);
    @(posedge sys_clk);
    ap_wr <= 1'h1;
    ap_addr <= a;
    ap_split <= sp;
    ap_be <= 4'hf;
    ap_wdata <= v;
    repeat (n) @(posedge sys_clk);
    ap_wr <= 1'h0;
  endtask
  // bounded wait, a hang shows up as busy still high
  task wait_idle();
    int i;
    i = 0;
    #1;
    while (busy !== 1'h0 && i < 2000)
    begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(busy, 1'h0)
  endtask
  // watcher: each start takes the oldest noted destination address
  always @(posedge busy)
  begin
    #1;
    `CHK(wk_dst_addr, exp_q.pop_front())
    `CHK({x_pos, y_pos}, 24'h0)
  end
  // result counters and host data comparison
  always @(posedge sys_clk)
  begin
    if (mem_we === 1'h1)
      n_mem++;
    if (host_rvalid === 1'h1)
      n_host++;
    if (write_fault === 1'h1)
      n_flt++;
    // memory-fed ops run fg cc (source) and bg 33 (inverted source)
    if (mem_we === 1'h1 && dq.size() > 0)
      `CHK(mem_wdata, dq.pop_front())
    else if (mem_we === 1'h1)
      `CHK(mem_wdata, mix_q ? src_q : ~src_q)
    if (host_rvalid === 1'h1)
      `CHK(host_rdata, mix_q ? src_q : ~src_q)
    src_q = mem_src;
    mix_q = mem_mix;
  end
  initial
  begin
    #100000;
    fail_count++;
    test_done();
  end
  initial
  begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'h1;
    #1;
    `CHK(write_status, 1'h1)
    @(posedge sys_clk);
    q_src_addr <= $random(seed);
    q_mix_addr <= $random(seed);
    q_pat_addr <= $random(seed);
    op_state(8'h01);
    #1;
    `CHK(wk_src_addr, q_src_addr)
    `CHK(wk_pat_addr, q_pat_addr)
    // memory copy to display memory, then to the host
    for (int ds = 0; ds < 2; ds++)
    begin
      @(posedge sys_clk);
      destination_route_select <= ds[0];
      q_bg_rop <= 8'h33;
      q_src_offset <= {8'h01, 8'($random(seed))};
      op_state(8'h00);
      n_mem = 0;
      n_host = 0;
      start_op($random(seed));
      repeat (10) @(posedge sys_clk);
      `CHK(n_mem + n_host, 0)
      op_state(8'h10);
      wait_idle();
      `CHK(n_mem, ds ? 0 : 8)
      `CHK(n_host, ds ? 8 : 0)
      `CHK(wk_src_addr, q_src_addr + {q_src_offset, 1'h0})
      `CHK(wk_pat_addr, q_pat_addr)
    end
    // host source, one aligned line, a split cycle first
    @(posedge sys_clk);
    input_route_select <= 2'h1;
    destination_route_select <= 1'h0;
    q_bg_rop <= 8'h0f;
    vertical_count <= 12'h0;
    q_src_addr <= 32'h00001000;
    n_mem = 0;
    d = $random(seed);
    start_op(d);
    ap_put(2'h1, 1'h1, 32'h0, 1);
    repeat (2) @(posedge sys_clk);
    `CHK(n_flt, 1)
    `CHK(byte_rot, 2'h0 - d[1:0])
    `CHK(bit_rot, q_mix_addr[4:0])
    d = $random(seed);
    for (int k = 0; k < 4; k++)
      dq.push_back(d[8*k +: 8]);
    // second cycle of the held write is refused and raises wait; ap_put still drops ap_wr after two cycles
    ap_put(2'h0, 1'h0, d, 2);
    wait_idle();
    `CHK(n_mem, 4)
    `CHK(dq.size(), 0)
    test_done();
  end
endmodule
`default_nettype wire
